// ==== common/pmae_pkg.sv ====
// constants and types of the alert, output-two and energy command logic
// assumes a bus engine that turns wire traffic into decoded commands
// Contract
// - voltage warning alert enables, default off
// - current limit, overpower alert enables, default off
// - output two mode: alert, gpo, reserved, comparator
// - comparator mode shows unlatched OR of warnings
// - polarity bit: 0 active low, 1 high
// - device configuration byte at 0xD8, reset 0x00
// - bit 7 picks short overcurrent glitch filter
// - bit 6 keeps foldback off current limit
// - operation command refused while bit 5 low
// - bit 4 makes current warning two overcurrent
// - configuration low nibble reads as zero
// - peak power word at 0xDA, zero write clears
// - peak holds max power, bit 15 zero
// - 0xDB block: count 3, product low first
// - 0xDC block: count 8, eight data bytes
// - bytes 1-3 energy accumulator, low first
// - bytes 4-5 rollover count, low first
// - bytes 6-8 sample count, low first
// - alert config two at 0xD6, reset 0x8000
package pmae_pkg;
   // ******************************
   // command codes
   // ******************************
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ALERT_CFG = 8'hD6;
   localparam logic [7:0] CMD_DEV_CFG   = 8'hD8;
   localparam logic [7:0] CMD_PWR_CYCLE = 8'hD9;
   localparam logic [7:0] CMD_PEAK_PIN  = 8'hDA;
   localparam logic [7:0] CMD_PIN_EXT   = 8'hDB;
   localparam logic [7:0] CMD_EIN_EXT   = 8'hDC;
   // ******************************
   // reset values, counts, fields
   // ******************************
   localparam logic [15:0] ALERT_CFG_RST = 16'h8000;
   localparam logic [7:0]  DEV_CFG_RST   = 8'h00;
   localparam logic [14:0] PEAK_RST      = 15'h0000;
   localparam logic [7:0]  DEV_CFG_WMASK = 8'hF0;
   localparam logic [7:0]  PIN_EXT_COUNT = 8'h03;
   localparam logic [7:0]  EIN_EXT_COUNT = 8'h08;
   localparam int ALERT_EN_HI = 8;
   localparam int ALERT_EN_LO = 3;
   localparam int MODE_HI     = 2;
   localparam int MODE_LO     = 1;
   localparam int POL_BIT     = 0;
   localparam int FILT_BIT    = 7;
   localparam int FLB_BIT     = 6;
   localparam int OPEN_BIT    = 5;
   localparam int WARN2_BIT   = 4;
   localparam logic [1:0] MODE_ALERT = 2'h0;
   localparam logic [1:0] MODE_GPO   = 2'h1;
   localparam logic [1:0] MODE_CMP   = 2'h3;
   // ******************************
   // types
   // ******************************
   typedef enum logic [2:0] {
      KIND_WR_BYTE = 3'h1,
      KIND_WR_WORD = 3'h2,
      KIND_READ    = 3'h3,
      KIND_SEND    = 3'h4,
      KIND_BLK_RD  = 3'h5
   } pmae_kind_t;
   typedef enum logic {
      BLK_IDLE = 1'b0,
      BLK_SEND = 1'b1
   } pmae_blk_t;
   typedef struct packed {
      logic        valid;
      pmae_kind_t  kind;
      logic [7:0]  code;
      logic [15:0] data;
   } pmae_cmd_t;
   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [15:0] data;
   } pmae_resp_t;
   // order matches alert enable bits 8 down to 3
   typedef struct packed {
      logic in_ov;
      logic in_uv;
      logic out_ov;
      logic out_uv;
      logic cur_lim;
      logic overpower;
   } pmae_warn_t;
   typedef struct packed {
      logic        valid;
      logic [14:0] word;
      logic [23:0] ext;
   } pmae_sample_t;
   typedef struct packed {
      logic [15:0] alert_cfg;
      logic [7:0]  dev_cfg;
      logic [14:0] peak;
      logic [23:0] pin_ext;
      logic [23:0] energy;
      logic [15:0] roll;
      logic [23:0] samples;
      logic [63:0] blk;
      logic [3:0]  left;
      pmae_blk_t   bst;
      pmae_resp_t  resp;
      logic [7:0]  byte_d;
      logic        byte_v;
      logic        cycle_p;
      logic        oper_p;
      logic [7:0]  oper_d;
      logic        alert;
      logic        pin;
   } pmae_state_t;
endpackage

// ==== rtl/pmae_regs.sv ====
// command registers for alerts, output two, peak power and energy
// assumes decoded commands and samples on the same clock
`timescale 1ns/1ps
module pmae_regs
   import pmae_pkg::*;
(
   input  wire logic         mclk_in,
   input  wire logic         reset_in,
   input  wire pmae_cmd_t    cmd_in,
   input  wire logic         byte_req_in,
   input  wire pmae_warn_t   status_in,
   input  wire pmae_warn_t   compare_in,
   input  wire pmae_sample_t sample_in,
   output pmae_resp_t        resp_out,
   output logic [7:0]        byte_out,
   output logic              byte_valid_out,
   output logic [15:0]       alert_cfg_out,
   output logic              alert_out,
   output logic              output_two_pin_out,
   output logic              filter_short_out,
   output logic              foldback_disable_out,
   output logic              current_warn_two_select_out,
   output logic              power_cycle_out,
   output logic              operation_out,
   output logic [7:0]        operation_data_out
);
   // ******************************
   // state
   // ******************************
   pmae_state_t s_reg;
   pmae_state_t s_next;
   logic [24:0] esum;
   logic [5:0]  en6;
   logic        alert_now;
   logic        cmp_now;
   logic        act;
   logic [1:0]  mode;

   function automatic logic is_wr(input pmae_cmd_t c, input pmae_kind_t k);
      is_wr = c.kind == k;
   endfunction

   // ******************************
   // next state
   // ******************************
   always_comb begin
      s_next = s_reg;
      esum = '0;
      en6 = s_reg.alert_cfg[ALERT_EN_HI:ALERT_EN_LO];
      mode = s_reg.alert_cfg[MODE_HI:MODE_LO];
      s_next.resp = '0;
      s_next.cycle_p = 1'b0;
      s_next.oper_p = 1'b0;
      s_next.byte_v = 1'b0;
      // block stream walks out low byte first
      if (s_reg.bst == BLK_SEND && byte_req_in) begin
         s_next.byte_d = s_reg.blk[7:0];
         s_next.blk = s_reg.blk >> 8;
         s_next.left = s_reg.left - 4'h1;
         s_next.byte_v = 1'b1;
         if (s_reg.left == 4'h1) begin
            s_next.bst = BLK_IDLE;
         end
      end
      // a new command aborts an unfinished block stream
      if (cmd_in.valid) begin
         s_next.resp.valid = 1'b1;
         // bytes of a dropped stream are never sent
         s_next.bst = BLK_IDLE;
         s_next.byte_v = 1'b0;
         s_next.resp.ack = 1'b1;
         unique case (cmd_in.code)
            CMD_ALERT_CFG: begin
               if (is_wr(cmd_in, KIND_WR_WORD)) begin
                  s_next.alert_cfg = cmd_in.data;
               end else if (is_wr(cmd_in, KIND_READ)) begin
                  s_next.resp.data = s_reg.alert_cfg;
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            CMD_DEV_CFG: begin
               if (is_wr(cmd_in, KIND_WR_BYTE)) begin
                  s_next.dev_cfg = cmd_in.data[7:0] & DEV_CFG_WMASK;
               end else if (is_wr(cmd_in, KIND_READ)) begin
                  s_next.resp.data = {8'h00, s_reg.dev_cfg};
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            CMD_PWR_CYCLE: begin
               s_next.resp.ack = is_wr(cmd_in, KIND_SEND);
               s_next.cycle_p = is_wr(cmd_in, KIND_SEND);
            end
            CMD_PEAK_PIN: begin
               if (is_wr(cmd_in, KIND_WR_WORD)) begin
                  s_next.peak = cmd_in.data[14:0];
               end else if (is_wr(cmd_in, KIND_READ)) begin
                  s_next.resp.data = {1'b0, s_reg.peak};
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            CMD_PIN_EXT: begin
               if (is_wr(cmd_in, KIND_BLK_RD)) begin
                  s_next.resp.data = {8'h00, PIN_EXT_COUNT};
                  s_next.blk = {40'h0, s_reg.pin_ext};
                  s_next.left = 4'h3;
                  s_next.bst = BLK_SEND;
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            CMD_EIN_EXT: begin
               if (is_wr(cmd_in, KIND_BLK_RD)) begin
                  s_next.resp.data = {8'h00, EIN_EXT_COUNT};
                  // one snapshot keeps all eight bytes consistent
                  s_next.blk = {s_reg.samples, s_reg.roll, s_reg.energy};
                  s_next.left = 4'h8;
                  s_next.bst = BLK_SEND;
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            CMD_OPERATION: begin
               // guards against a card switching itself off
               if (s_reg.dev_cfg[OPEN_BIT] && is_wr(cmd_in, KIND_WR_BYTE)) begin
                  s_next.oper_p = 1'b1;
                  s_next.oper_d = cmd_in.data[7:0];
               end else begin
                  s_next.resp.ack = 1'b0;
               end
            end
            default: begin
               s_next.resp.ack = 1'b0;
            end
         endcase
      end
      // sample after the write so a new peak beats a clear
      if (sample_in.valid) begin
         esum = {1'b0, s_reg.energy} + {10'h000, sample_in.word};
         s_next.energy = esum[23:0];
         s_next.samples = s_reg.samples + 24'h000001;
         s_next.pin_ext = sample_in.ext;
         if (esum[24]) begin
            s_next.roll = s_reg.roll + 16'h0001;
         end
         if (sample_in.word > s_next.peak) begin
            s_next.peak = sample_in.word;
         end
      end
      // ******************************
      // alert and output two
      // ******************************
      alert_now = |(en6 & status_in);
      cmp_now = |(en6 & compare_in);
      unique case (mode)
         MODE_ALERT: act = alert_now;
         MODE_CMP:   act = cmp_now;
         default:    act = 1'b0;
      endcase
      s_next.alert = alert_now;
      if (mode == MODE_GPO) begin
         s_next.pin = s_reg.alert_cfg[POL_BIT];
      end else begin
         s_next.pin = s_reg.alert_cfg[POL_BIT] ? act : ~act;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         s_reg <= '0;
         s_reg.alert_cfg <= ALERT_CFG_RST;
         s_reg.dev_cfg <= DEV_CFG_RST;
         s_reg.peak <= PEAK_RST;
         s_reg.bst <= BLK_IDLE;
         s_reg.pin <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign resp_out = s_reg.resp;
   assign byte_out = s_reg.byte_d;
   assign byte_valid_out = s_reg.byte_v;
   assign alert_cfg_out = s_reg.alert_cfg;
   assign alert_out = s_reg.alert;
   assign output_two_pin_out = s_reg.pin;
   assign filter_short_out = s_reg.dev_cfg[FILT_BIT];
   assign foldback_disable_out = s_reg.dev_cfg[FLB_BIT];
   assign current_warn_two_select_out = s_reg.dev_cfg[WARN2_BIT];
   assign power_cycle_out = s_reg.cycle_p;
   assign operation_out = s_reg.oper_p;
   assign operation_data_out = s_reg.oper_d;

   // ******************************
   // assertions
   // ******************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   sequence ein_start;
      cmd_in.valid && cmd_in.code == CMD_EIN_EXT && cmd_in.kind == KIND_BLK_RD;
   endsequence
   sequence pin_start;
      cmd_in.valid && cmd_in.code == CMD_PIN_EXT && cmd_in.kind == KIND_BLK_RD;
   endsequence

   ein_count_a: assert property (ein_start |=> resp_out.ack && resp_out.data == 16'h0008)
      else $error("energy block count wrong");
   pin_count_a: assert property (pin_start |=> resp_out.ack && resp_out.data == 16'h0003)
      else $error("power block count wrong");
   sequence byte_pull;
      s_reg.bst == BLK_SEND && byte_req_in && !cmd_in.valid;
   endsequence
   sequence op_open;
      cmd_in.valid && cmd_in.code == CMD_OPERATION && cmd_in.kind == KIND_WR_BYTE && s_reg.dev_cfg[OPEN_BIT];
   endsequence

   ein_first_a: assert property (ein_start ##1 (byte_req_in && !cmd_in.valid)
      |=> byte_valid_out && byte_out == $past(s_reg.energy[7:0], 2))
      else $error("energy low byte wrong");
   pin_first_a: assert property (pin_start ##1 (byte_req_in && !cmd_in.valid)
      |=> byte_valid_out && byte_out == $past(s_reg.pin_ext[7:0], 2))
      else $error("power low byte wrong");
   byte_step_a: assert property (byte_pull |=> byte_valid_out && byte_out == $past(s_reg.blk[7:0]))
      else $error("block byte not delivered");
   byte_idle_a: assert property (!byte_req_in |=> !byte_valid_out)
      else $error("byte valid without request");
   resp_answer_a: assert property (cmd_in.valid |=> resp_out.valid)
      else $error("command got no response");
   resp_quiet_a: assert property (!cmd_in.valid |=> !resp_out.valid)
      else $error("response without command");
   dev_reserved_a: assert property (cmd_in.valid && cmd_in.code == CMD_DEV_CFG && cmd_in.kind == KIND_READ
      |=> resp_out.data[3:0] == 4'h0)
      else $error("reserved config bits not zero");
   cfg_write_a: assert property (cmd_in.valid && cmd_in.code == CMD_DEV_CFG && cmd_in.kind == KIND_WR_BYTE
      |=> s_reg.dev_cfg == ($past(cmd_in.data[7:0]) & DEV_CFG_WMASK))
      else $error("config write not stored");
   peak_top_a: assert property (cmd_in.valid && cmd_in.code == CMD_PEAK_PIN && cmd_in.kind == KIND_READ
      |=> !resp_out.data[15])
      else $error("peak bit 15 set");
   peak_clear_a: assert property (cmd_in.valid && cmd_in.code == CMD_PEAK_PIN && cmd_in.kind == KIND_WR_WORD
      && cmd_in.data == 16'h0000 && !sample_in.valid |=> s_reg.peak == 15'h0000)
      else $error("peak not cleared");
   peak_max_a: assert property (sample_in.valid |=> s_reg.peak >= $past(sample_in.word))
      else $error("peak below sample");
   op_gate_a: assert property (cmd_in.valid && cmd_in.code == CMD_OPERATION && !s_reg.dev_cfg[OPEN_BIT]
      |=> resp_out.valid && !resp_out.ack && !operation_out)
      else $error("operation accepted while disabled");
   op_pass_a: assert property (op_open |=> operation_out && resp_out.ack
      && operation_data_out == $past(cmd_in.data[7:0]))
      else $error("enabled operation not accepted");
   cycle_send_a: assert property (cmd_in.valid && cmd_in.code == CMD_PWR_CYCLE && cmd_in.kind == KIND_SEND
      |=> power_cycle_out && resp_out.ack)
      else $error("power cycle not accepted");
   cycle_kind_a: assert property (cmd_in.valid && cmd_in.code == CMD_PWR_CYCLE && cmd_in.kind != KIND_SEND
      |=> !power_cycle_out && !resp_out.ack)
      else $error("power cycle with wrong kind");
   cycle_only_a: assert property (!(cmd_in.valid && cmd_in.code == CMD_PWR_CYCLE) |=> !power_cycle_out)
      else $error("power cycle without command");
   acfg_write_a: assert property (cmd_in.valid && cmd_in.code == CMD_ALERT_CFG
      && cmd_in.kind == KIND_WR_WORD |=> alert_cfg_out == $past(cmd_in.data))
      else $error("alert config write not stored");
   alert_en_a: assert property (|(s_reg.alert_cfg[ALERT_EN_HI:ALERT_EN_LO] & status_in)
      |=> alert_out)
      else $error("enabled warning gave no alert");
   alert_quiet_a: assert property (!(|(en6 & status_in)) |=> !alert_out)
      else $error("alert without enabled status");
   // the pin lags the config by one cycle, so its level is judged
   // against the polarity that stood one edge back
   gpo_level_a: assert property (s_reg.alert_cfg[MODE_HI:MODE_LO] == MODE_GPO && $stable(s_reg.alert_cfg)
      |=> output_two_pin_out == $past(s_reg.alert_cfg[POL_BIT]))
      else $error("gpo pin level wrong");
   alert_pin_a: assert property (mode == MODE_ALERT && |(en6 & status_in)
      |=> output_two_pin_out == $past(s_reg.alert_cfg[POL_BIT]))
      else $error("alert mode pin not active");
   alert_idle_a: assert property (mode == MODE_ALERT && !(|(en6 & status_in))
      |=> output_two_pin_out != $past(s_reg.alert_cfg[POL_BIT]))
      else $error("alert mode pin not idle");
   mode_reserved_a: assert property (mode != MODE_ALERT && mode != MODE_GPO && mode != MODE_CMP
      |=> output_two_pin_out != $past(s_reg.alert_cfg[POL_BIT]))
      else $error("reserved mode drove pin");
   cmp_pin_a: assert property (s_reg.alert_cfg[MODE_HI:MODE_LO] == MODE_CMP && $stable(s_reg.alert_cfg)
      && |(s_reg.alert_cfg[ALERT_EN_HI:ALERT_EN_LO] & compare_in)
      |=> output_two_pin_out == $past(s_reg.alert_cfg[POL_BIT]))
      else $error("comparator pin not active");
   cmp_idle_a: assert property (mode == MODE_CMP && !(|(en6 & compare_in))
      |=> output_two_pin_out != $past(s_reg.alert_cfg[POL_BIT]))
      else $error("comparator pin active without warning");
   roll_step_a: assert property (sample_in.valid
      && ({1'b0, s_reg.energy} + {10'h000, sample_in.word}) > 25'hFFFFFF
      |=> s_reg.roll == $past(s_reg.roll) + 16'h0001)
      else $error("rollover not counted");
   roll_hold_a: assert property (!sample_in.valid |=> s_reg.roll == $past(s_reg.roll))
      else $error("rollover moved without sample");
   sample_count_a: assert property (sample_in.valid |=> s_reg.samples == $past(s_reg.samples) + 24'h000001)
      else $error("sample not counted");
   cfg_reset_a: assert property ($fell(reset_in) |-> alert_cfg_out == 16'h8000 && s_reg.dev_cfg == 8'h00
      && s_reg.peak == 15'h0000)
      else $error("reset values wrong");
endmodule

// ==== tb/pmae_host_model.sv ====
// host side model: issues decoded commands and pulls block read bytes
// assumes the register block answers one cycle after each request
`timescale 1ns/1ps
module pmae_host_model
   import pmae_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire pmae_resp_t resp_in,
   input  wire logic [7:0] byte_in,
   input  wire logic       byte_valid_in,
   output pmae_cmd_t       cmd_out,
   output logic            byte_req_out
);
   initial begin
      cmd_out = '0;
      byte_req_out = 1'b0;
   end
   task automatic xfer(input pmae_kind_t k, input logic [7:0] c, input logic [15:0] d, output pmae_resp_t r);
      @(posedge mclk_in);
      cmd_out <= '{1'b1, k, c, (k == KIND_SEND) ? 16'h0000 : d};
      @(posedge mclk_in);
      // idle data inverted so a stale word is never mistaken for a live one
      cmd_out <= '{1'b0, k, c, ~d};
      #1 r = resp_in;
   endtask
   task automatic get_byte(output logic [7:0] b, output logic v);
      @(posedge mclk_in);
      byte_req_out <= 1'b1;
      @(posedge mclk_in);
      byte_req_out <= 1'b0;
      #1 b = byte_in;
      v = byte_valid_in;
   endtask
endmodule

// ==== tb/pmae_regs_test.sv ====
// self-checking bench of the alert, output-two, peak and energy registers
// assumes the host model drives commands; bench drives status and samples
`timescale 1ns/1ps
module pmae_regs_test;
   import pmae_pkg::*;
   logic mclk_in, reset_in, byte_req, byte_valid, alert, pin, filt, foldback_input, sel, pcyc, oper;
   logic [7:0] byte_d, oper_d;
   logic [15:0] acfg;
   pmae_cmd_t cmd;
   pmae_resp_t resp, r;
   pmae_warn_t status_in, compare_in;
   pmae_sample_t sample_in;
   int failures, n_compared, cycles;
   pmae_regs u_pmae_regs (.mclk_in(mclk_in), .reset_in(reset_in), .cmd_in(cmd), .byte_req_in(byte_req),
      .status_in(status_in), .compare_in(compare_in), .sample_in(sample_in), .resp_out(resp),
      .byte_out(byte_d), .byte_valid_out(byte_valid), .alert_cfg_out(acfg), .alert_out(alert),
      .output_two_pin_out(pin), .filter_short_out(filt), .foldback_disable_out(foldback_input),
      .current_warn_two_select_out(sel), .power_cycle_out(pcyc), .operation_out(oper),
      .operation_data_out(oper_d));
   pmae_host_model u_pmae_host_model (.mclk_in(mclk_in), .resp_in(resp), .byte_in(byte_d),
      .byte_valid_in(byte_valid), .cmd_out(cmd), .byte_req_out(byte_req));
   // ************
   // helpers
   // ************
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   task automatic report_and_stop();
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic do_reset();
      @(posedge mclk_in);
      reset_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      reset_in <= 1'b0;
   endtask
   task automatic wr(input pmae_kind_t k, input logic [7:0] c, input logic [15:0] d, input logic ack);
      u_pmae_host_model.xfer(k, c, d, r);
      chk(32'({r.valid, r.ack}), 32'({1'b1, ack}));
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      u_pmae_host_model.xfer(KIND_READ, c, 16'h0000, r);
      chk(32'({r.valid, r.ack, r.data}), 32'({2'b11, e}));
   endtask
   task automatic feed(input logic [14:0] w, input int n);
      @(posedge mclk_in);
      sample_in <= '{1'b1, w, 24'h123456};
      repeat (n) @(posedge mclk_in);
      sample_in.valid <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic blk(input logic [7:0] c, input logic [3:0] n, input logic [63:0] e, input logic poke);
      logic [7:0] b;
      logic v;
      u_pmae_host_model.xfer(KIND_BLK_RD, c, 16'h0000, r);
      chk(32'({r.valid, r.data}), 32'({1'b1, 12'h000, n}));
      // a late sample must not leak into the bytes already snapshotted
      if (poke) feed(15'h0001, 1);
      for (int i = 0; i < n; i++) begin
         u_pmae_host_model.get_byte(b, v);
         chk(32'({v, b}), 32'({1'b1, e[8*i+:8]}));
      end
   endtask
   task automatic settle_pin(input pmae_warn_t s, input pmae_warn_t c, input logic e);
      @(posedge mclk_in);
      status_in <= s;
      compare_in <= c;
      repeat (3) @(posedge mclk_in);
      #1 chk(32'(pin), 32'(e));
   endtask
   // ************
   // scenarios
   // ************
   task automatic test_reset();
      rd(CMD_ALERT_CFG, 16'h8000);
      rd(CMD_DEV_CFG, 16'h0000);
      rd(CMD_PEAK_PIN, 16'h0000);
      chk(32'({acfg, alert, pin}), 32'({16'h8000, 2'b01}));
   endtask
   task automatic test_config();
      wr(KIND_WR_BYTE, CMD_DEV_CFG, 16'h00FF, 1'b1);
      rd(CMD_DEV_CFG, 16'h00F0);
      chk(32'({filt, foldback_input, sel}), 32'h7);
      wr(KIND_WR_BYTE, CMD_DEV_CFG, 16'h0000, 1'b1);
      chk(32'({filt, foldback_input, sel}), 32'h0);
   endtask
   task automatic test_commands();
      wr(KIND_WR_BYTE, CMD_OPERATION, 16'h0055, 1'b0);
      chk(32'(oper), 32'h0);
      wr(KIND_WR_BYTE, CMD_DEV_CFG, 16'h0020, 1'b1);
      wr(KIND_WR_BYTE, CMD_OPERATION, 16'h0055, 1'b1);
      chk(32'({oper, oper_d}), 32'h155);
      wr(KIND_SEND, CMD_PWR_CYCLE, 16'h0000, 1'b1);
      chk(32'(pcyc), 32'h1);
      wr(KIND_READ, 8'hD7, 16'h0000, 1'b0);
      wr(KIND_WR_WORD, CMD_PIN_EXT, 16'h1234, 1'b0);
      wr(KIND_WR_BYTE, CMD_DEV_CFG, 16'h0000, 1'b1);
   endtask
   task automatic test_alerts();
      for (int i = 0; i < 6; i++) begin
         wr(KIND_WR_WORD, CMD_ALERT_CFG, 16'(16'h0008 << i), 1'b1);
         settle_pin(pmae_warn_t'(~(6'h01 << i)), '0, 1'b1);
         chk(32'(alert), 32'h0);
         settle_pin(pmae_warn_t'(6'h01 << i), '0, 1'b0);
         chk(32'(alert), 32'h1);
      end
      settle_pin('0, '0, 1'b1);
   endtask
   task automatic test_pin_modes();
      wr(KIND_WR_WORD, CMD_ALERT_CFG, 16'h0003, 1'b1);
      settle_pin('0, '0, 1'b1);
      wr(KIND_WR_WORD, CMD_ALERT_CFG, 16'h0002, 1'b1);
      settle_pin('0, '0, 1'b0);
      // reserved mode keeps the pin idle even with every warning enabled and set
      wr(KIND_WR_WORD, CMD_ALERT_CFG, 16'h01FC, 1'b1);
      settle_pin(pmae_warn_t'(6'h3F), pmae_warn_t'(6'h3F), 1'b1);
      wr(KIND_WR_WORD, CMD_ALERT_CFG, 16'h1107, 1'b1);
      settle_pin('0, pmae_warn_t'(6'h20), 1'b1);
      settle_pin(pmae_warn_t'(6'h3F), pmae_warn_t'(6'h1F), 1'b0);
      settle_pin('0, '0, 1'b0);
   endtask
   task automatic test_peak();
      feed(15'h0100, 1);
      feed(15'h0300, 1);
      feed(15'h0200, 1);
      rd(CMD_PEAK_PIN, 16'h0300);
      feed(15'h7FFF, 1);
      rd(CMD_PEAK_PIN, 16'h7FFF);
      wr(KIND_WR_WORD, CMD_PEAK_PIN, 16'h0000, 1'b1);
      rd(CMD_PEAK_PIN, 16'h0000);
   endtask
   task automatic test_energy();
      logic [7:0] b;
      logic v;
      do_reset();
      // 513 full-scale samples carry the accumulator out of 24 bits once
      feed(15'h7FFF, 513);
      blk(CMD_PIN_EXT, 4'h3, 64'h0000000000123456, 1'b0);
      blk(CMD_EIN_EXT, 4'h8, 64'h0002010001007DFF, 1'b1);
      // a command before the first byte drops the whole stream
      u_pmae_host_model.xfer(KIND_BLK_RD, CMD_PIN_EXT, 16'h0000, r);
      rd(CMD_DEV_CFG, 16'h0000);
      u_pmae_host_model.get_byte(b, v);
      chk(32'(v), 32'h0);
   endtask
   initial begin
      reset_in = 1'b1;
      status_in = '0;
      compare_in = '0;
      sample_in = '0;
      repeat (4) @(posedge mclk_in);
      reset_in <= 1'b0;
      test_reset();
      test_config();
      test_commands();
      test_alerts();
      test_pin_modes();
      test_peak();
      test_energy();
      report_and_stop();
   end
endmodule
